// ===== shared/adc_ctrl_params.svh
// Constants for the converter control block: register map, field positions and timing.
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define REG_CTRL1          8'h00
`define REG_CTRL3          8'h04
`define REG_CHSEL          8'h08
`define REG_TRIG           8'h0c
`define REG_STATUS         8'h10
`define REG_RESULT0        8'h14
`define REG_RESULT1        8'h18

// ==========================================================================
// Field positions
// ==========================================================================
`define CTRL1_PWM_EN_BIT   0
`define CTRL1_EXT_EN_BIT   1
`define CTRL1_CONT_BIT     2
`define CTRL1_PAIR_BIT     3
`define CTRL1_ACQ_LSB      8
`define CTRL1_ACQ_MSB      11
`define CTRL3_PWR_BIT      5
`define CTRL3_BGR_LSB      6
`define CTRL3_BGR_MSB      7
`define TRIG_SW_BIT        0
`define STAT_BUSY_BIT      0
`define STAT_READY_BIT     1
`define STAT_FLAG_BIT      2
`define STAT_OVERRUN_BIT   3
`define STAT_BGR_OK_BIT    4
`define STAT_PWD_OK_BIT    5

// ==========================================================================
// Timing
// ==========================================================================
`define PCLK_HZ            20000000
`define BGR_SETTLE_MS      5
`define BGR_SETTLE_CYCLES  ((`BGR_SETTLE_MS * `PCLK_HZ + 999) / 1000)
`define PWD_SETTLE_US      20
`define PWD_SETTLE_CYCLES  ((`PWD_SETTLE_US * `PCLK_HZ + 999999) / 1000000)
`define CONV_DIV           6'd2
`define TRIG_DELAY_HALF    6'd5
`define TRIG_DELAY_CYCLES  ((`TRIG_DELAY_HALF * `CONV_DIV) / 6'd2)
`define RESULT_LAT_CONV    4
`define PIPE_DEPTH         (`RESULT_LAT_CONV * 2)
`define GAP_CYCLES         (`CONV_DIV)
`define FLAG_DELAY         2

`endif

// ===== shared/adc_ctrl_pkg.sv
// Types shared by the converter control block and its leaf modules.
package adc_ctrl_pkg;

  // ========================================================================
  // Control block: sequencer states and register state
  // ========================================================================
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_HOLD  = 2'b10,
    ST_GAP   = 2'b11
  } seq_state_e;

  typedef struct packed {
    seq_state_e  state;
    logic [5:0]  cnt;
    logic [3:0]  acq;
    logic        pair_mode;
    logic        continuous;
    logic        pwm_en;
    logic        ext_en;
    logic [1:0]  bgr_bits;
    logic        power;
    logic [3:0]  channel;
    logic [11:0] result0;
    logic [11:0] result1;
    logic [1:0]  flag_pipe;
    logic        conv_flag;
    logic        overrun;
    logic        pwm_prev;
    logic        ext_prev;
    logic        sh_pulse;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ctrl_state_s;

  // ========================================================================
  // Leaf modules
  // ========================================================================
  typedef struct packed {
    logic [16:0] cnt;
    logic        done;
  } timer_state_s;

  typedef logic [25:0] pipe_word_t;

  typedef struct packed {
    pipe_word_t [7:0] stage;
  } pipe_state_s;

endpackage : adc_ctrl_pkg

// ===== rtl/settle_timer.sv
// Settling timer that reports done once its enable has been held for a set count.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module settle_timer #(
  parameter int unsigned COUNT = 400
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic enable,
  output logic      done
);

  adc_ctrl_pkg::timer_state_s cur;
  adc_ctrl_pkg::timer_state_s nxt;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Dropping the enable restarts the wait, so a brief power glitch is never trusted.
  always_comb begin
    nxt = cur;
    if (!enable) begin
      nxt.cnt  = 17'h00000;
      nxt.done = 1'b0;
    end else begin
      if (!cur.done) begin
        nxt.cnt = cur.cnt + 17'h00001;
      end
      nxt.done = cur.done || (cur.cnt == 17'(COUNT - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign done = cur.done;

endmodule : settle_timer

// ===== rtl/conversion_pipe.sv
// Eight-stage conversion pipeline, each stage one system clock long.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module conversion_pipe (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Samples in
  input  wire logic        in_valid,
  input  wire logic [24:0] in_data,
  // Results out
  output logic             out_valid,
  output logic [24:0]      out_data
);

  adc_ctrl_pkg::pipe_state_s cur;
  adc_ctrl_pkg::pipe_state_s nxt;

  // ==========================================================================
  // Shift
  // ==========================================================================
  // A new sample may enter while older ones are still in flight.
  always_comb begin
    nxt = cur;
    nxt.stage[0] = {in_valid, in_data};
    for (int i = 1; i < `PIPE_DEPTH; i++) begin
      nxt.stage[i] = cur.stage[i-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign out_valid = cur.stage[`PIPE_DEPTH-1][25];
  assign out_data  = cur.stage[`PIPE_DEPTH-1][24:0];

endmodule : conversion_pipe

// ===== rtl/adc_ctrl.sv
// Converter control block: power-up sequencing, triggers, sample/hold timing, results.
//
// Notes on behaviour
// - All three power bits in one write work; ready after reference settling.
// - Sixteen input channels, sampled singly or as a pair, chosen by software.
// - Mode bit zero is single-channel sampling, one is paired sampling.
// - Single-channel mode can convert continuously on any channel of either group.
// - Conversions start from the PWM trigger, software trigger or external trigger.
// - Single-channel mode converts the selected channel once per sample/hold pulse.
// - The selected channel is sampled on each falling sample/hold edge.
// - Sample/hold pulse lasts from one to sixteen converter clocks.
// - Pulse width is one plus the four-bit acquisition count, bits 8 to 11.
// - Sampling begins two and a half converter clocks after the trigger.
// - First result reaches the result register four converter clocks after sampling.
// - Successive results follow two plus acquisition count converter clocks apart.
// - The conversion flag rises a few system clocks after the result update.
// - The conversion core is an eight-stage pipeline accepting overlapping samples.
// - Paired mode converts both channels of the pair together on every pulse.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module adc_ctrl #(
  parameter int unsigned BGR_SETTLE_CYCLES = `BGR_SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Trigger sources
  input  wire logic         pwm_trigger_source,
  input  wire logic         external_convert_trigger,
  // Analog channels, sixteen 12-bit values, channel n in bits 12n+11:12n
  input  wire logic [191:0] channel_data,
  // Converter outputs
  output logic              sample_hold_pulse,
  output logic [11:0]       result0,
  output logic [11:0]       result1,
  output logic              conversion_flag
);

  adc_ctrl_pkg::ctrl_state_s cur;
  adc_ctrl_pkg::ctrl_state_s next_s;

  logic        bgr_done;
  logic        pwd_done;
  logic        pipe_valid;
  logic [24:0] pipe_data;

  // ==========================================================================
  // Power-up settling
  // ==========================================================================
  settle_timer #(
    .COUNT (BGR_SETTLE_CYCLES)
  ) bgr_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (&cur.bgr_bits),
    .done    (bgr_done)
  );

  settle_timer #(
    .COUNT (`PWD_SETTLE_CYCLES)
  ) pwd_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (cur.power),
    .done    (pwd_done)
  );

  // ==========================================================================
  // Sampling and pipeline
  // ==========================================================================
  logic        conv_ready;
  logic        sample_now;
  logic [3:0]  idx_a;
  logic [3:0]  idx_b;
  logic [11:0] sample_a;
  logic [11:0] sample_b;
  logic [5:0]  hold_load;

  // The power timer starts with the reference timer, so one write of all three works.
  assign conv_ready = bgr_done && pwd_done && cur.power && (&cur.bgr_bits);
  assign hold_load  = 6'((({2'b00, cur.acq} + 6'd1) * `CONV_DIV) - 6'd1);
  assign sample_now = (cur.state == adc_ctrl_pkg::ST_HOLD) && (cur.cnt == 6'd0);
  assign idx_a      = cur.pair_mode ? {1'b0, cur.channel[2:0]} : cur.channel;
  assign idx_b      = {1'b1, cur.channel[2:0]};
  assign sample_a   = channel_data[12*idx_a +: 12];
  assign sample_b   = channel_data[12*idx_b +: 12];

  conversion_pipe pipe (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (sample_now),
    .in_data   ({cur.pair_mode, cur.pair_mode ? sample_b : 12'h000, sample_a}),
    .out_valid (pipe_valid),
    .out_data  (pipe_data)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic setup;
  logic wr;
  logic [5:0] reg_sel;
  logic pwm_edge;
  logic ext_edge;
  logic sw_trig;
  logic trig;
  logic mapped;
  logic [31:0] rd_val;

  always_comb begin
    next_s   = cur;
    setup    = psel && !penable;
    wr       = psel && penable && cur.pready && pwrite;
    reg_sel  = paddr[7:2];
    pwm_edge = pwm_trigger_source && !cur.pwm_prev && cur.pwm_en;
    ext_edge = external_convert_trigger && !cur.ext_prev && cur.ext_en;
    sw_trig  = wr && (reg_sel == 6'(`REG_TRIG >> 2)) && pwdata[`TRIG_SW_BIT];
    trig     = pwm_edge || ext_edge || sw_trig;
    mapped   = 1'b1;
    rd_val   = 32'h00000000;

    next_s.pwm_prev = pwm_trigger_source;
    next_s.ext_prev = external_convert_trigger;

    // Register writes.
    if (wr) begin
      unique case (reg_sel)
        6'(`REG_CTRL1 >> 2): begin
          next_s.pwm_en     = pwdata[`CTRL1_PWM_EN_BIT];
          next_s.ext_en     = pwdata[`CTRL1_EXT_EN_BIT];
          next_s.continuous = pwdata[`CTRL1_CONT_BIT];
          next_s.pair_mode  = pwdata[`CTRL1_PAIR_BIT];
          next_s.acq        = pwdata[`CTRL1_ACQ_MSB:`CTRL1_ACQ_LSB];
        end
        6'(`REG_CTRL3 >> 2): begin
          next_s.bgr_bits = pwdata[`CTRL3_BGR_MSB:`CTRL3_BGR_LSB];
          next_s.power    = pwdata[`CTRL3_PWR_BIT];
        end
        6'(`REG_CHSEL >> 2): begin
          next_s.channel = pwdata[3:0];
        end
        6'(`REG_STATUS >> 2): begin
          if (pwdata[`STAT_FLAG_BIT]) begin
            next_s.conv_flag = 1'b0;
          end
          if (pwdata[`STAT_OVERRUN_BIT]) begin
            next_s.overrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Sequencer.
    unique case (cur.state)
      adc_ctrl_pkg::ST_IDLE: begin
        if (trig && conv_ready) begin
          next_s.state = adc_ctrl_pkg::ST_DELAY;
          next_s.cnt   = 6'(`TRIG_DELAY_CYCLES - 6'd1);
        end
      end
      adc_ctrl_pkg::ST_DELAY: begin
        if (cur.cnt == 6'd0) begin
          next_s.state    = adc_ctrl_pkg::ST_HOLD;
          next_s.cnt      = hold_load;
          next_s.sh_pulse = 1'b1;
        end else begin
          next_s.cnt = cur.cnt - 6'd1;
        end
      end
      adc_ctrl_pkg::ST_HOLD: begin
        if (cur.cnt == 6'd0) begin
          // One sample per pulse; the pipe captures it at this edge.
          next_s.sh_pulse = 1'b0;
          if (cur.continuous) begin
            next_s.state = adc_ctrl_pkg::ST_GAP;
            next_s.cnt   = 6'(`GAP_CYCLES - 6'd1);
          end else begin
            next_s.state = adc_ctrl_pkg::ST_IDLE;
          end
        end else begin
          next_s.cnt = cur.cnt - 6'd1;
        end
      end
      adc_ctrl_pkg::ST_GAP: begin
        if (cur.cnt == 6'd0) begin
          next_s.state    = adc_ctrl_pkg::ST_HOLD;
          next_s.cnt      = hold_load;
          next_s.sh_pulse = 1'b1;
        end else begin
          next_s.cnt = cur.cnt - 6'd1;
        end
      end
    endcase

    // A trigger while a conversion is running is dropped and remembered.
    if (trig && (cur.state != adc_ctrl_pkg::ST_IDLE)) begin
      next_s.overrun = 1'b1;
    end

    // Losing converter power stops the sequencer at once.
    if (!conv_ready) begin
      next_s.state    = adc_ctrl_pkg::ST_IDLE;
      next_s.sh_pulse = 1'b0;
    end

    // Results leave the pipe four converter clocks after the falling edge.
    if (pipe_valid) begin
      next_s.result0 = pipe_data[11:0];
      if (pipe_data[24]) begin
        next_s.result1 = pipe_data[23:12];
      end
    end

    // The flag trails the result update; a set in the clear cycle wins.
    next_s.flag_pipe = {cur.flag_pipe[0], pipe_valid};
    if (cur.flag_pipe[`FLAG_DELAY-1]) begin
      next_s.conv_flag = 1'b1;
    end

    // Read data, captured in the setup cycle; zero wait states.
    unique case (reg_sel)
      6'(`REG_CTRL1 >> 2): begin
        rd_val[`CTRL1_PWM_EN_BIT]              = cur.pwm_en;
        rd_val[`CTRL1_EXT_EN_BIT]              = cur.ext_en;
        rd_val[`CTRL1_CONT_BIT]                = cur.continuous;
        rd_val[`CTRL1_PAIR_BIT]                = cur.pair_mode;
        rd_val[`CTRL1_ACQ_MSB:`CTRL1_ACQ_LSB]  = cur.acq;
      end
      6'(`REG_CTRL3 >> 2): begin
        rd_val[`CTRL3_BGR_MSB:`CTRL3_BGR_LSB] = cur.bgr_bits;
        rd_val[`CTRL3_PWR_BIT]                = cur.power;
      end
      6'(`REG_CHSEL >> 2): begin
        rd_val[3:0] = cur.channel;
      end
      6'(`REG_TRIG >> 2): begin
        rd_val = 32'h00000000;
      end
      6'(`REG_STATUS >> 2): begin
        rd_val[`STAT_BUSY_BIT]    = (cur.state != adc_ctrl_pkg::ST_IDLE);
        rd_val[`STAT_READY_BIT]   = conv_ready;
        rd_val[`STAT_FLAG_BIT]    = cur.conv_flag;
        rd_val[`STAT_OVERRUN_BIT] = cur.overrun;
        rd_val[`STAT_BGR_OK_BIT]  = bgr_done;
        rd_val[`STAT_PWD_OK_BIT]  = pwd_done;
      end
      6'(`REG_RESULT0 >> 2): begin
        rd_val[11:0] = cur.result0;
      end
      6'(`REG_RESULT1 >> 2): begin
        rd_val[11:0] = cur.result1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    next_s.pready = setup;
    if (setup) begin
      next_s.prdata  = rd_val;
      next_s.pslverr = !mapped;
    end else if (!psel) begin
      next_s.pslverr = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_s;
    end
  end

  assign prdata            = cur.prdata;
  assign pready            = cur.pready;
  assign pslverr           = cur.pslverr;
  assign sample_hold_pulse = cur.sh_pulse;
  assign result0           = cur.result0;
  assign result1           = cur.result1;
  assign conversion_flag   = cur.conv_flag;

endmodule : adc_ctrl

// ===== dv/adc_ctrl_checker.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module adc_ctrl_checker #(
  parameter int unsigned BGR_SETTLE_CYCLES = `BGR_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // APB
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Triggers and channels
  input wire logic         pwm_trigger_source,
  input wire logic         external_convert_trigger,
  input wire logic [191:0] channel_data,
  // Converter outputs
  input wire logic         sample_hold_pulse,
  input wire logic [11:0]  result0,
  input wire logic [11:0]  result1,
  input wire logic         conversion_flag
);
  // ==========
  // Helpers
  // ==========
  logic [5:0] hi_cnt;
  logic [3:0] acq;
  logic       pwm_d;
  logic       ext_d;
  wire logic  wr_go = psel && penable && pready && pwrite;
  // Trigger enables are not tracked, so this only says a start had a possible cause.
  wire logic  trig_ev = (wr_go && paddr == `REG_TRIG && pwdata[0]) ||
                        (pwm_trigger_source && !pwm_d) || (external_convert_trigger && !ext_d);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 6'h00;
      acq    <= 4'h0;
      pwm_d  <= 1'b0;
      ext_d  <= 1'b0;
    end else begin
      hi_cnt <= sample_hold_pulse ? hi_cnt + 6'h01 : 6'h00;
      if (wr_go && paddr == `REG_CTRL1) begin
        acq <= pwdata[11:8];
      end
      pwm_d  <= pwm_trigger_source;
      ext_d  <= external_convert_trigger;
    end
  end

  // ==========
  // Properties
  // ==========
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_start_delay: assert property (
    $rose(sample_hold_pulse) |-> $past(trig_ev, 6) || $past(sample_hold_pulse, 3))
    else $error("pulse rose without a cause six cycles before");
  a_width_exact: assert property (
    $fell(sample_hold_pulse) |-> hi_cnt == {acq, 1'b0} + 6'h02)
    else $error("pulse width differs from the acquisition count");
  a_width_max: assert property (hi_cnt <= 6'h20)
    else $error("pulse longer than sixteen converter clocks");
  a_gap_min: assert property ($fell(sample_hold_pulse) |=> !sample_hold_pulse)
    else $error("pulse gap shorter than one converter clock");
  a_result_lat: assert property (
    $changed(result0) |-> $past(sample_hold_pulse, 9) && !$past(sample_hold_pulse, 8))
    else $error("result0 changed away from its slot");
  a_pair_lat: assert property (
    $changed(result1) |-> $past(sample_hold_pulse, 9) && !$past(sample_hold_pulse, 8))
    else $error("result1 changed away from its slot");
  a_one_per_pulse: assert property ($changed(result0) |=> $stable(result0) [*3])
    else $error("result0 updated twice within one period");
  a_flag_delay: assert property ($fell(sample_hold_pulse) |-> ##10 conversion_flag)
    else $error("flag not set after the result");
  a_flag_cause: assert property (
    $rose(conversion_flag) |-> $past(sample_hold_pulse, 11) && !$past(sample_hold_pulse, 10))
    else $error("flag rose without a result two cycles before");
endmodule : adc_ctrl_checker

// ===== dv/trig_source_model.sv
// Behavioural trigger sources and analog channel values for the converter bench.
`timescale 1ns/100ps

module trig_source_model (
  // Clock
  input  wire logic    pclk,
  // Trigger lines
  output logic         pwm_trigger_source,
  output logic         external_convert_trigger,
  // Analog channels
  output logic [191:0] channel_data
);
  logic [31:0] mix = 32'h0;

  initial begin
    pwm_trigger_source = 1'b0;
    external_convert_trigger = 1'b0;
    channel_data = '0;
  end

  // Every channel moves each cycle, so a sample taken one cycle off shows.
  always @(posedge pclk) begin
    mix <= mix + 32'h9e3779b9;
    channel_data <= {channel_data[179:0], mix[11:0]};
  end

  // The line rises, is seen at the next edge and falls two cycles later.
  task automatic fire(input int which);
    @(posedge pclk);
    if (which == 1) pwm_trigger_source <= 1'b1;
    else external_convert_trigger <= 1'b1;
    @(posedge pclk);
    fork
      begin
        repeat (2) @(posedge pclk);
        pwm_trigger_source <= 1'b0;
        external_convert_trigger <= 1'b0;
      end
    join_none
  endtask : fire
endmodule : trig_source_model

// ===== dv/tb.sv
// Testbench: APB master, behavioural result model and conversion scenarios.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module tb;
  // ==========
  // Signals
  // ==========
  logic         pclk;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         pwm;
  logic         ext;
  logic [191:0] chan;
  logic         sh;
  logic [11:0]  r0;
  logic [11:0]  r1;
  logic         flag;
  logic [31:0]  rd;
  logic         err;
  logic [31:0]  lfsr = 32'hfb3d89a4;
  logic [31:0]  ctrl;
  logic [3:0]   acq;
  logic         sh_d = 1'b0;
  logic [191:0] chan_d = '0;
  logic [11:0]  e0_q[$];
  logic [11:0]  e1_q[$];
  int           due_q[$];
  int           num_errors = 0;
  int           num_checks = 0;
  int           cyc = 0;
  int           flag_due = -1;
  int           cur_ch = 0;
  int           cur_pair = 0;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  adc_ctrl #(.BGR_SETTLE_CYCLES(50)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_trigger_source(pwm), .external_convert_trigger(ext), .channel_data(chan),
    .sample_hold_pulse(sh), .result0(r0), .result1(r1), .conversion_flag(flag));

  trig_source_model src_u (.pclk(pclk), .pwm_trigger_source(pwm),
    .external_convert_trigger(ext), .channel_data(chan));

  // ==========
  // Tasks
  // ==========
  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic tally_and_finish;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic trig(input int k);
    if (k == 0) apb(1'b1, `REG_TRIG, 32'h1);
    else src_u.fire(k);
  endtask : trig

  task automatic expect_pulse(input logic [3:0] a);
    repeat (5) @(posedge pclk);
    check(32'(sh), 32'h0, "pulse early");
    @(posedge pclk);
    check(32'(sh), 32'h1, "pulse start");
    repeat (2 * (1 + int'(a)) - 1) @(posedge pclk);
    check(32'(sh), 32'h1, "pulse held");
    @(posedge pclk);
    check(32'(sh), 32'h0, "pulse end");
  endtask : expect_pulse

  // Each falling pulse edge books the sampled channels for the result slot.
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (sh_d === 1'b1 && sh === 1'b0) begin
      due_q.push_back(cyc + 8);
      e0_q.push_back(chan_d[12 * (cur_pair != 0 ? cur_ch % 8 : cur_ch) +: 12]);
      e1_q.push_back(chan_d[12 * (cur_ch % 8 + 8) +: 12]);
    end
    if (due_q.size() > 0 && due_q[0] == cyc) begin
      check(32'(r0), 32'(e0_q[0]), "result0");
      if (cur_pair != 0) check(32'(r1), 32'(e1_q[0]), "result1");
      flag_due = cyc + 2;
      due_q.delete(0);
      e0_q.delete(0);
      e1_q.delete(0);
    end
    if (cyc == flag_due) check(32'(flag), 32'h1, "flag");
    sh_d <= sh;
    chan_d <= chan;
  end

  // ==========
  // Scenarios
  // ==========
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_CTRL1, 32'h0);
    check(rd, 32'h0, "ctrl1 reset");
    apb(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0, "unmapped data");
    check(32'(err), 32'h1, "unmapped error");
    // Converter power without the reference must not convert.
    apb(1'b1, `REG_CTRL3, 32'h20);
    repeat (450) @(posedge pclk);
    trig(0);
    repeat (12) begin
      @(posedge pclk);
      check(32'(sh), 32'h0, "pulse unpowered");
    end
    apb(1'b1, `REG_CTRL3, 32'h0);
    apb(1'b1, `REG_CTRL3, 32'he0);
    repeat (20) @(posedge pclk);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd, 32'h0, "status settling");
    repeat (420) @(posedge pclk);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd, 32'h32, "status ready");
    // Last pass runs continuously at the shortest pulse, so samples overlap.
    for (int k = 0; k < 7; k++) begin
      lfsr = nxt(lfsr);
      acq = (k == 1) ? 4'hf : (k == 0 || k == 6) ? 4'h0 : lfsr[3:0];
      cur_ch = int'(lfsr[7:4]);
      cur_pair = (k >= 3 && k < 6) ? 1 : 0;
      ctrl = 32'h3 | (32'(cur_pair) << 3) | (32'(k == 6) << 2) | (32'(acq) << 8);
      apb(1'b1, `REG_CTRL1, ctrl);
      apb(1'b0, `REG_CTRL1, 32'h0);
      check(rd, ctrl, "ctrl1 readback");
      apb(1'b1, `REG_CHSEL, 32'(cur_ch));
      apb(1'b1, `REG_STATUS, 32'h4);
      @(posedge pclk);
      check(32'(flag), 32'h0, "flag cleared");
      trig(k % 3);
      expect_pulse(acq);
      if (k == 6) begin
        @(posedge pclk);
        check(32'(sh), 32'h0, "gap held");
        @(posedge pclk);
        check(32'(sh), 32'h1, "next pulse");
        repeat (10) @(posedge pclk);
        // A trigger while busy is dropped and marked as an overrun.
        trig(0);
        apb(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h3f, "status overrun");
        apb(1'b1, `REG_CTRL1, ctrl & ~32'h4);
        repeat (40) @(posedge pclk);
        check(32'(sh), 32'h0, "continuous stopped");
      end
      repeat (14) @(posedge pclk);
    end
    check(32'(due_q.size()), 32'h0, "pending results");
    tally_and_finish();
  end
endmodule : tb

bind adc_ctrl adc_ctrl_checker #(.BGR_SETTLE_CYCLES(BGR_SETTLE_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_trigger_source(pwm_trigger_source), .external_convert_trigger(external_convert_trigger),
  .channel_data(channel_data), .sample_hold_pulse(sample_hold_pulse), .result0(result0),
  .result1(result1), .conversion_flag(conversion_flag));
